// File: src/burst_pulse_generator.sv
// burst pulse generator with phase, repetition and return forwarding
`timescale 1ns/1ps
`default_nettype none
`include "burst_pulse_consts.svh"
module burst_pulse_generator (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cfgWrite,
  input wire logic [2:0] cfgAddr,
  input wire logic [23:0] cfgData,
  input wire logic startCycle,
  input wire logic [3:0] pulseCount,
  input wire logic [1:0] predivSel,
  input wire logic [3:0] fireDiv,
  input wire logic fireReturn,
  output logic driveOutA,
  output logic driveOutAEn,
  output logic driveOutB,
  output logic driveOutBEn,
  output logic burstBusy
);
  import burst_pulse_pkg::*;

  gen_state_type s;
  gen_state_type next_s;
  logic refTick;
  logic level;
  logic fwdGate;
  logic invB;

  ////////////////////////////////////////////////////////////////////
  // reference tick source
  burst_tick_divider divider (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .predivSel(predivSel),
    .fireDiv(fireDiv),
    .refTick(refTick)
  );

  ////////////////////////////////////////////////////////////////////
  // return forwarding gate, only up to the programmed pulse count when it is below 15
  assign invB = s.cfg[`INV_B_BIT];
  assign fwdGate = (s.state == ST_LISTEN)
    && ((s.rxCount < s.cnt)
    || ((s.rxCount == s.cnt) && s.prevRet));

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_s = s;
    level = 1'b0;
    next_s.prevRet = fireReturn;
    next_s.lfsr = {s.lfsr[6:0],
      s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3]};
    // write-only config register
    if (cfgWrite && (cfgAddr == `REG_FIRE_CFG)) begin
      next_s.cfg = cfgData;
    end
    next_s.enA = !s.cfg[`HIZ_A_BIT];
    next_s.enB = !s.cfg[`HIZ_B_BIT];
    unique case (s.state)
      ST_IDLE: begin
        next_s.outA = 1'b0;
        next_s.outB = invB;
        // zero count keeps the generator off
        if (startCycle && (pulseCount != 4'h0)) begin
          next_s.cnt = pulseCount;
          next_s.idx = 4'h0;
          next_s.half = 1'b0;
          next_s.tickCount = 6'h00;
          next_s.repLeft = s.cfg[`REPEAT_MSB:`REPEAT_LSB];
          next_s.busy = 1'b1;
          if (!s.cfg[`NOISE_OFF_BIT]) begin
            next_s.noiseWait = s.lfsr[1:0];
            next_s.state = ST_NOISE;
          end else begin
            next_s.state = ST_FIRE;
          end
        end
      end
      ST_NOISE: begin
        // random 1..4 tick start offset dithers the burst phase
        if (refTick) begin
          if (s.noiseWait == 2'h0) begin
            next_s.state = ST_FIRE;
          end else begin
            next_s.noiseWait = s.noiseWait - 2'h1;
          end
        end
      end
      ST_FIRE: begin
        if (refTick) begin
          next_s.tickCount = s.tickCount + 6'h01;
          if (s.idx == s.cnt) begin
            next_s.outA = 1'b0;
            next_s.outB = invB;
            next_s.rxCount = 4'h0;
            next_s.quiet = 10'h000;
            if (s.repLeft == 3'h0) begin
              next_s.state = ST_IDLE;
              next_s.busy = 1'b0;
            end else begin
              next_s.state = ST_LISTEN;
            end
          end else begin
            // lsb first, first half is the inverse of the phase bit
            level = s.cfg[s.idx] ^ !s.half;
            next_s.outA = level;
            next_s.outB = level ^ invB;
            next_s.half = !s.half;
            if (s.half) begin
              next_s.idx = s.idx + 4'h1;
            end
          end
        end
      end
      ST_LISTEN: begin
        if (fireReturn && !s.prevRet && (s.rxCount != 4'hf)) begin
          next_s.rxCount = s.rxCount + 4'h1;
        end
        if (fireReturn) begin
          next_s.quiet = 10'h000;
        end else if (s.quiet != 10'(`QUIET_CYCLES - 1)) begin
          next_s.quiet = s.quiet + 10'h001;
        end
        // a silent gap only closes a sequence once pulses were seen
        if (!fireReturn && (s.quiet == 10'(`QUIET_CYCLES - 1))
          && (s.rxCount != 4'h0)) begin
          next_s.repLeft = s.repLeft - 3'h1;
          next_s.rxCount = 4'h0;
          next_s.quiet = 10'h000;
          if (s.repLeft == 3'h1) begin
            next_s.state = ST_IDLE;
            next_s.busy = 1'b0;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.state <= ST_IDLE;
      s.cfg <= `FIRE_CFG_RESET;
      s.lfsr <= `LFSR_RESET;
      s.enA <= 1'b1;
      s.enB <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // drivers: forwarding path bypasses the flops so re-emission has
  // no clock delay; everything else leaves a flip-flop
  assign driveOutA = fwdGate ? fireReturn : s.outA;
  assign driveOutB = fwdGate ? (fireReturn ^ invB) : s.outB;
  assign driveOutAEn = s.enA;
  assign driveOutBEn = s.enB;
  assign burstBusy = s.busy;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  start_takes_a: assert property (
    (s.state == ST_IDLE && startCycle && pulseCount != 4'h0)
      |=> (s.state != ST_IDLE) && burstBusy)
    else $error("start command not taken");

  zero_count_a: assert property (
    (s.state == ST_IDLE && pulseCount == 4'h0) |=> s.state == ST_IDLE)
    else $error("zero pulse count fired");

  burst_length_a: assert property (
    (s.state == ST_FIRE && next_s.state != ST_FIRE)
      |-> s.tickCount == {1'b0, s.cnt, 1'b0})
    else $error("burst tick count wrong");

  first_phase_a: assert property (
    (s.state == ST_FIRE && refTick && s.idx == 4'h0 && !s.half)
      |=> s.half && (s.outA == !s.cfg[`PHASE_LSB]))
    else $error("first pulse phase wrong");

  repeat_load_a: assert property (
    (s.state == ST_FIRE && next_s.state == ST_LISTEN)
      |-> s.repLeft == s.cfg[`REPEAT_MSB:`REPEAT_LSB]
      && s.repLeft != 3'h0)
    else $error("repetition count not loaded");

  quiet_end_a: assert property (
    (s.state == ST_LISTEN && next_s.repLeft != s.repLeft)
      |-> s.quiet == 10'(`QUIET_CYCLES - 1) && !fireReturn)
    else $error("sequence ended before quiet gap");

  forward_path_a: assert property (
    (s.state == ST_LISTEN && s.rxCount < s.cnt)
      |-> driveOutA == fireReturn)
    else $error("return pulse not forwarded");

  idle_steady_a: assert property (
    (s.state == ST_IDLE && $past(s.state) == ST_IDLE)
      |-> !driveOutA && driveOutB == $past(invB))
    else $error("outputs toggle while idle");

  hiz_follow_a: assert property (
    $past(s.cfg[`HIZ_A_BIT]) |-> !driveOutAEn)
    else $error("output A not released");

  burst_done_c: cover property (
    s.state == ST_FIRE ##1 s.state == ST_IDLE);
  repeat_done_c: cover property (
    s.state == ST_LISTEN ##1 s.state == ST_IDLE);
  noise_wait_c: cover property (
    s.state == ST_NOISE && s.noiseWait == 2'h3);

endmodule
`default_nettype wire

// File: src/burst_pulse_consts.svh
// constants for the burst pulse generator
// Behaviour
// - The base burst clock is the fast oscillator clock divided by the predivider setting.
// - The base clock is doubled, then divided by the fire divider plus one to give the reference tick; a fire divider of zero is treated as one.
// - A burst carries as many pulses as the pulse count, 1 to 15, and a count of zero disables firing.
// - A burst starts only on the start-cycle command, and the host starts every burst that way.
// - Each pulse takes one bit of the 16-bit phase field, zero giving high-low and one giving low-high.
// - Phase bits are used from the least significant bit upward, one per pulse.
// - Each pulse takes two reference ticks, one for each half.
// - Bit 19 clear enables the noise phase shift and bit 19 set disables it.
// - Bit 23 inverts output B, bit 22 puts output B in high-Z, and bit 21 puts output A in high-Z.
// - Bits 16 to 18 give the number of extra repetitions, from 0 to 7.
// - Each repetition forwards exactly the programmed number of pulses and no more; at a count of 15 later pulses still pass after their first cycle.
// - Five microseconds with no pulse end a received pulse sequence.
// - During repetition, the return input passes straight to the drivers with no clock delay.
`ifndef BURST_PULSE_CONSTS_SVH
`define BURST_PULSE_CONSTS_SVH

`define REG_FIRE_CFG 3'h5
`define FIRE_CFG_RESET 24'h000000
`define PHASE_LSB 0
`define REPEAT_LSB 16
`define REPEAT_MSB 18
`define NOISE_OFF_BIT 19
`define HIZ_A_BIT 21
`define HIZ_B_BIT 22
`define INV_B_BIT 23
`define LFSR_RESET 8'h01

`define SYS_CLK_PERIOD_NS 8
`define QUIET_TIME_NS 5000
`define QUIET_CYCLES \
  ((`QUIET_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

// File: src/burst_pulse_pkg.sv
// types shared by the burst pulse generator
package burst_pulse_pkg;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_NOISE  = 4'b0010,
    ST_FIRE   = 4'b0100,
    ST_LISTEN = 4'b1000
  } gen_phase_type;

  typedef struct packed {
    gen_phase_type state;
    logic [23:0] cfg;
    logic [3:0] cnt;
    logic [3:0] idx;
    logic half;
    logic [2:0] repLeft;
    logic [3:0] rxCount;
    logic [9:0] quiet;
    logic [1:0] noiseWait;
    logic [7:0] lfsr;
    logic outA;
    logic outB;
    logic enA;
    logic enB;
    logic prevRet;
    logic busy;
    logic [5:0] tickCount;
  } gen_state_type;

  typedef struct packed {
    logic [7:0] acc;
    logic tick;
  } div_state_type;

endpackage

// File: src/burst_tick_divider.sv
// reference tick divider for the burst pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "burst_pulse_consts.svh"
module burst_tick_divider (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [1:0] predivSel,
  input wire logic [3:0] fireDiv,
  output logic refTick
);
  import burst_pulse_pkg::*;

  div_state_type s;
  div_state_type next_s;
  logic [3:0] divSafe;
  logic [7:0] thr;
  logic [7:0] sum;

  // fractional accumulator: adds two per clock (the doubling) against
  // (div+1) scaled by the predivider; avoids a second clock entirely
  always_comb begin
    next_s = s;
    divSafe = (fireDiv == 4'h0) ? 4'h1 : fireDiv;
    // predivider 0/1/2 gives 1/2/4, code 3 held at 4
    thr = 8'((9'(divSafe) + 9'h001)
      << ((predivSel == 2'h3) ? 2'h2 : predivSel));
    sum = s.acc + 8'h02;
    if (sum >= thr) begin
      next_s.acc = sum - thr;
      next_s.tick = 1'b1;
    end else begin
      next_s.acc = sum;
      next_s.tick = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign refTick = s.tick;

endmodule
`default_nettype wire

// File: tb/echo_partner.sv
// transducer echo model feeding the receive line
`timescale 1ns/1ps
`default_nettype none
module echo_partner (
  input wire logic sys_clk,
  input wire logic driveOutA,
  input wire logic echoGo,
  input wire logic [3:0] echoPulses,
  output logic fireReturn,
  output logic [4:0] seenEdges
);
  logic [4:0] left;
  logic [1:0] ph;
  logic prevA;
  initial begin
    left = 5'h00;
    ph = 2'h0;
    prevA = 1'b0;
    seenEdges = 5'h00;
  end
  // echo short enough that all repetitions stay in range
  always @(posedge sys_clk) begin
    if (echoGo) begin
      left <= {1'b0, echoPulses};
      ph <= 2'h0;
    end else if (left != 5'h00) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) left <= left - 5'h01;
    end
  end
  // receiver comparator idles low between echoes
  assign fireReturn = (left != 5'h00) && !ph[1];
  // count rising edges that driver A actually emits
  always @(posedge sys_clk) begin
    prevA <= driveOutA;
    if (echoGo) seenEdges <= 5'h00;
    else if (driveOutA && !prevA) seenEdges <= seenEdges + 5'h01;
  end
endmodule
`default_nettype wire

// File: tb/burst_pulse_generator_bench.sv
// self-checking bench for the burst pulse generator
`timescale 1ns/1ps
`default_nettype none
module burst_pulse_generator_bench;
  logic sys_clk, resetn, cfgWrite, startCycle, fireReturn, echoGo;
  logic [2:0] cfgAddr;
  logic [23:0] cfgData;
  logic [3:0] pulseCount, fireDiv, echoPulses;
  logic [1:0] predivSel;
  logic driveOutA, driveOutAEn, driveOutB, driveOutBEn, burstBusy;
  logic [4:0] seenEdges;
  int err_count, total_checks;
  burst_pulse_generator burst_pulse_generator_inst (.sys_clk(sys_clk),
    .resetn(resetn), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
    .cfgData(cfgData), .startCycle(startCycle), .pulseCount(pulseCount),
    .predivSel(predivSel), .fireDiv(fireDiv), .fireReturn(fireReturn),
    .driveOutA(driveOutA), .driveOutAEn(driveOutAEn),
    .driveOutB(driveOutB), .driveOutBEn(driveOutBEn),
    .burstBusy(burstBusy));
  echo_partner echo_partner_inst (.sys_clk(sys_clk), .driveOutA(driveOutA),
    .echoGo(echoGo), .echoPulses(echoPulses), .fireReturn(fireReturn),
    .seenEdges(seenEdges));
  ////////////////////////////////////////////////////////////////////////
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic write_cfg(input logic [2:0] a, input logic [23:0] d);
    @(negedge sys_clk);
    cfgWrite = 1'b1;
    cfgAddr = a;
    cfgData = d;
    @(negedge sys_clk);
    cfgWrite = 1'b0;
  endtask
  task automatic start(input logic [3:0] cnt);
    @(negedge sys_clk);
    pulseCount = cnt;
    startCycle = 1'b1;
    @(negedge sys_clk);
    startCycle = 1'b0;
  endtask
  // bounded wait for the burst to end, n = busy cycles
  task automatic wait_idle(output int n, input int lim);
    n = 0;
    @(negedge sys_clk);
    while (burstBusy === 1'b1) begin
      if (n >= lim) begin
        err_count++;
        final_report();
      end
      @(negedge sys_clk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // one tick per clock; a restart mid-burst must be ignored
  task automatic pulse_walk(input logic [3:0] cnt, input logic [15:0] ph,
                            input logic inv);
    int i;
    write_cfg(3'h5, {inv, 4'h1, 3'h0, ph});
    write_cfg(3'h3, {~inv, 23'h0}); // unmapped, no effect
    start(cnt);
    check1(burstBusy, 1'b1);
    for (i = 0; i < 2 * cnt; i++) begin
      @(negedge sys_clk);
      // restart lands in the middle of the first pulse
      startCycle = (i == 0);
      check1(driveOutA, ph[i / 2] ^ (i % 2 == 0));
      check1(driveOutB, ph[i / 2] ^ (i % 2 == 0) ^ inv);
    end
    @(negedge sys_clk);
    check1(driveOutA, 1'b0);
    check1(burstBusy, 1'b0);
  endtask
  task automatic zero_count();
    int k;
    start(4'h0);
    for (k = 0; k < 4; k++) begin
      @(negedge sys_clk);
      check1(burstBusy, 1'b0);
      check1(driveOutA, 1'b0);
    end
  endtask
  task automatic hiz_check();
    int m;
    for (m = 3; m >= 0; m--) begin
      write_cfg(3'h5, {1'b0, m[1:0], 2'b01, 19'h0});
      repeat (2) @(negedge sys_clk);
      check1(driveOutAEn, ~m[0]);
      check1(driveOutBEn, ~m[1]);
    end
  endtask
  // busy spans three ticks of p clocks: 2p to 3p-1 cycles counted
  task automatic div_check(input logic [1:0] pd, input logic [3:0] dv,
                           input int lo, input int hi);
    int n;
    write_cfg(3'h5, 24'h080000);
    predivSel = pd;
    fireDiv = dv; // never zero
    start(4'h1);
    wait_idle(n, 200);
    check1(n >= lo && n <= hi, 1'b1);
  endtask
  // noise delays the first pulse by one to four ticks
  task automatic noise_check();
    int n;
    write_cfg(3'h5, 24'h000000);
    start(4'h1);
    n = 0;
    @(negedge sys_clk);
    while (driveOutA !== 1'b1 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    check1(n >= 1 && n <= 4, 1'b1);
    // first pulse never came: stop here rather than chase a dead burst
    if (n >= 10) begin
      err_count++;
      final_report();
    end
    wait_idle(n, 50);
  endtask
  // one repetition of two pulses while the echo carries three
  task automatic repeat_check();
    int n;
    int k;
    write_cfg(3'h5, 24'h090000);
    start(4'h2);
    repeat (8) @(negedge sys_clk);
    echoGo = 1'b1;
    @(negedge sys_clk);
    echoGo = 1'b0;
    for (k = 0; k < 4; k++) begin
      check1(driveOutA, k < 2);
      check1(driveOutB, k < 2);
      @(negedge sys_clk);
    end
    repeat (8) @(negedge sys_clk);
    check1(seenEdges == 5'h02, 1'b1);
    check1(burstBusy, 1'b1);
    wait_idle(n, 1000);
    check1(n >= 600 && n <= 640, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    cfgWrite = 1'b0;
    cfgAddr = 3'h0;
    cfgData = 24'h000000;
    startCycle = 1'b0;
    pulseCount = 4'h0;
    predivSel = 2'h0;
    fireDiv = 4'h1;
    echoGo = 1'b0;
    echoPulses = 4'h3;
    err_count = 0;
    total_checks = 0;
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    check1(driveOutA, 1'b0);
    check1(driveOutB, 1'b0);
    check1(driveOutAEn, 1'b1);
    check1(burstBusy, 1'b0);
    pulse_walk(4'h1, 16'h0000, 1'b0);
    pulse_walk(4'h4, 16'h0005, 1'b1);
    pulse_walk(4'hf, 16'ha5c3, 1'b0);
    zero_count();
    hiz_check();
    div_check(2'h0, 4'h1, 2, 2);
    div_check(2'h0, 4'h3, 4, 5);
    div_check(2'h1, 4'h1, 4, 5);
    div_check(2'h2, 4'h1, 8, 11);
    div_check(2'h3, 4'h1, 8, 11);
    div_check(2'h0, 4'h7, 8, 11);
    predivSel = 2'h0;
    fireDiv = 4'h1;
    noise_check();
    repeat_check();
    final_report();
  end
endmodule
`default_nettype wire
